// ==== rbc_far_model.sv ====
// far-side model: kickback converter and nonvolatile store
// assumes a one-cycle start pulse and a commit level from the block
`timescale 1ns/10ps
module rbc_far_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_adc_start,  // one conversion wanted
  input  wire logic       i_nv_write,   // commit in progress
  input  wire logic [3:0] i_lat,        // answer delay in cycles
  output logic            o_adc_done,
  output logic      [8:0] o_adc_data,
  output logic            o_nv_write_done
);
  int   acnt  = 0;     // cycles left in a conversion
  int   ncnt  = 0;     // cycles left in a store write
  logic nbusy = 1'b0;  // this commit already taken
  initial begin
    o_adc_done      = 1'b0;
    o_adc_data      = 9'h000;
    o_nv_write_done = 1'b0;
  end
  // answers move just after the falling edge, away from sampling
  always @(negedge i_sys_clk) begin
    o_adc_done      <= 1'b0;
    o_nv_write_done <= 1'b0;
    // data is valid only with done, so it keeps toggling otherwise
    o_adc_data      <= ~o_adc_data;
    if (!i_rst_n) begin
      acnt  = 0;
      ncnt  = 0;
      nbusy = 1'b0;
    end else begin
      if (i_adc_start)
        acnt = i_lat + 1;
      else if (acnt == 1) begin
        acnt = 0;
        o_adc_done <= 1'b1;
        o_adc_data <= 9'($urandom);
      end else if (acnt > 1)
        acnt--;
      // one done pulse per commit, slow or prompt by i_lat
      if (!i_nv_write)
        nbusy = 1'b0;
      else if (!nbusy) begin
        nbusy = 1'b1;
        ncnt  = i_lat + 1;
      end else if (ncnt == 1) begin
        ncnt = 0;
        o_nv_write_done <= 1'b1;
      end else if (ncnt > 1)
        ncnt--;
    end
  end
endmodule

// ==== rbc_pkg.sv ====
// constants, field layouts and types for the rail and bias control registers
// assumes a register port driven by a serial-bus slave elsewhere in the chip
//
// What this block does
// [RQ1] codes 011..110 select 15.000 down to 14.250 V
// [RQ2] host never writes rail codes 000, 001, 010
// [RQ3] low eight bias bits at offset 0x03
// [RQ4] writing one starts measurement, zero ignored
// [RQ5] measurement end clears start, stores result
// [RQ6] writing one commits bias code to nonvolatile
// [RQ7] commit end clears bit, enters idle state
// [RQ8] float bit one releases the bias pin
// [RQ9] float bit zero keeps amplifier on pin
// [RQ10] averaging field picks 1, 2, 4, 8 samples
// [RQ11] repeat conversions, return one averaged value
// [RQ12] bias code times minus ten millivolts
// [RQ13] flag measurement completion
// [RQ14] flag commit completion
// [RQ15] bias msb sits in bit 0 of 0x04
// [RQ16] power-up loads rail and bias from nonvolatile
package rbc_pkg;

  localparam int unsigned RBC_DATA_W = 8;   // register width
  localparam int unsigned RBC_CODE_W = 9;   // bias code width

  // register offsets
  localparam logic [7:0] RBC_OFS_RAIL      = 8'h02;
  localparam logic [7:0] RBC_OFS_BIAS_LOW  = 8'h03;
  localparam logic [7:0] RBC_OFS_BIAS_HIGH = 8'h04;

  // source rail level register layout
  typedef struct packed {
    logic [3:0] spare;   // read/write, no function
    logic       rsvd;    // read-only zero
    logic [2:0] level;   // rail_level_select
  } rbc_rail_reg_t;

  // bias high byte and control layout
  typedef struct packed {
    logic       start;     // kickback_measure_start
    logic       commit;    // bias_commit
    logic       float_pin; // bias_pin_float
    logic [1:0] avg;       // sample_average_count
    logic       spare_hi;  // read/write, no function
    logic       spare_lo;  // read/write, no function
    logic       code_msb;  // backplane_bias_code bit 8
  } rbc_ctrl_reg_t;

  // reset values before the nonvolatile load
  localparam logic [3:0] RBC_RAIL_SPARE_RST = 4'h2;
  localparam logic [2:0] RBC_LEVEL_DEF      = 3'h3;
  localparam logic [8:0] RBC_BIAS_DEF       = 9'h07D;
  localparam logic       RBC_SPARE_HI_RST   = 1'b1;

  // rail level encodings
  localparam logic [2:0] RBC_LVL_15000 = 3'h3;
  localparam logic [2:0] RBC_LVL_14750 = 3'h4;
  localparam logic [2:0] RBC_LVL_14500 = 3'h5;
  localparam logic [2:0] RBC_LVL_14250 = 3'h6;

  // rail magnitudes in millivolts
  localparam logic [15:0] RBC_MV_15000 = 16'h3A98;
  localparam logic [15:0] RBC_MV_14750 = 16'h399E;
  localparam logic [15:0] RBC_MV_14500 = 16'h38A4;
  localparam logic [15:0] RBC_MV_14250 = 16'h37AA;

  // bias step magnitude in millivolts, the sign is negative
  localparam logic [15:0] RBC_BIAS_STEP_MV = 16'h000A;

  // sequencer states, gray along load, idle, measure, commit
  typedef enum logic [1:0] {
    RBC_ST_LOAD = 2'b00,
    RBC_ST_IDLE = 2'b01,
    RBC_ST_MEAS = 2'b11,
    RBC_ST_BIAS_COMMIT = 2'b10
  } rbc_state_t;

  // rail magnitude of a level code, zero for an illegal code
  function automatic logic [15:0] rbc_level_mv(input logic [2:0] lvl);
    logic [15:0] mv;
    mv = '0;
    unique case (lvl)
      RBC_LVL_15000: mv = RBC_MV_15000;
      RBC_LVL_14750: mv = RBC_MV_14750;
      RBC_LVL_14500: mv = RBC_MV_14500;
      RBC_LVL_14250: mv = RBC_MV_14250;
      default:       mv = '0;
    endcase
    return mv;
  endfunction

endpackage

// ==== rbc_rail_bias_regs.sv ====
// rail level and backplane bias registers with the measure and commit engine
// assumes a serial-bus slave drives the register port, and that the
// converter and nonvolatile store answer with one-cycle done pulses
`timescale 1ns/10ps
module rbc_rail_bias_regs #(
  parameter int unsigned SHIFT_W = 2   // width of the averaging field
) (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rst_n,
  // register port behind the serial-bus slave
  input  wire logic [7:0]                     i_reg_addr,
  input  wire logic [rbc_pkg::RBC_DATA_W-1:0] i_reg_wdata,
  input  wire logic                           i_reg_wr,
  input  wire logic                           i_reg_rd,
  output logic      [rbc_pkg::RBC_DATA_W-1:0] o_reg_rdata,
  // nonvolatile store
  input  wire logic [2:0]                     i_nv_rail_level,
  input  wire logic [rbc_pkg::RBC_CODE_W-1:0] i_nv_bias_code,
  input  wire logic                           i_nv_write_done,
  output logic                                o_nv_write,
  output logic      [rbc_pkg::RBC_CODE_W-1:0] o_nv_wdata,
  // kickback converter
  input  wire logic                           i_adc_done,
  input  wire logic [rbc_pkg::RBC_CODE_W-1:0] i_adc_data,
  output logic                                o_adc_start,
  // analog settings
  output logic      [2:0]                     o_rail_level,
  output logic                                o_rail_valid,
  output logic      [15:0]                    o_rail_mv,
  output logic      [rbc_pkg::RBC_CODE_W-1:0] o_bias_code,
  output logic      [15:0]                    o_bias_neg_mv,
  output logic                                o_bias_pin_oe,
  output logic                                o_bias_pin_float,
  // events toward the interrupt and power-mode logic
  output logic                                o_measure_done_flag_set,
  output logic                                o_commit_done_flag_set,
  output logic                                o_enter_standby,
  output logic                                o_busy
);
  import rbc_pkg::*;

  rbc_state_t            state_ff;        // sequencer state
  rbc_state_t            nxt_state;       // next sequencer state
  rbc_rail_reg_t         rail_ff;         // source_rail_level register
  rbc_ctrl_reg_t         ctrl_ff;         // control bits of the high byte
  logic [RBC_CODE_W-1:0] bias_ff;         // backplane_bias_code
  logic [RBC_DATA_W-1:0] rdata_ff;        // read data holding register
  logic [3:0]            left_ff;         // samples still to convert
  logic [SHIFT_W-1:0]    shift_ff;        // averaging field at start
  logic                  adc_start_ff;    // converter start pulse
  logic                  nv_write_ff;     // commit request level
  logic [RBC_CODE_W-1:0] nv_wdata_ff;     // code being committed
  logic                  meas_flag_ff;    // measurement done pulse
  logic                  commit_flag_ff;  // commit done pulse
  logic                  standby_ff;      // idle entry pulse
  logic [2:0]            out_level_ff;    // registered level output
  logic                  out_valid_ff;    // level code is legal
  logic [15:0]           out_rail_mv_ff;  // registered rail magnitude
  logic [15:0]           out_bias_mv_ff;  // registered bias magnitude
  logic                  busy_ff;         // measure or commit running

  logic                  wr_rail;         // write strobe, rail register
  logic                  wr_low;          // write strobe, bias low byte
  logic                  wr_high;         // write strobe, high byte
  logic                  meas_enter;      // idle to measure this cycle
  logic                  bias_commit_enter;      // idle to commit this cycle
  logic                  sample_in;       // a sample arrives in measure
  logic                  meas_finish;     // last sample has arrived
  logic                  bias_commit_finish;     // store has finished commit
  logic [RBC_CODE_W-1:0] avg_result;      // averaged measurement
  rbc_ctrl_reg_t         wr_ctrl;         // write data seen as fields

  // address decode of the three register writes
  assign wr_rail = i_reg_wr && (i_reg_addr == RBC_OFS_RAIL);
  assign wr_low  = i_reg_wr && (i_reg_addr == RBC_OFS_BIAS_LOW);
  assign wr_high = i_reg_wr && (i_reg_addr == RBC_OFS_BIAS_HIGH);
  assign wr_ctrl = rbc_ctrl_reg_t'(i_reg_wdata);

  // sequencer events
  assign meas_enter  = (state_ff == RBC_ST_IDLE) && ctrl_ff.start;
  assign bias_commit_enter  = (state_ff == RBC_ST_IDLE) && !ctrl_ff.start
                       && ctrl_ff.commit;
  assign sample_in   = (state_ff == RBC_ST_MEAS) && i_adc_done;
  assign meas_finish = sample_in && (left_ff == 4'h1);
  assign bias_commit_finish = (state_ff == RBC_ST_BIAS_COMMIT) && i_nv_write_done;

  // next state; a pending measurement goes ahead of a pending commit
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RBC_ST_LOAD: begin
        nxt_state = RBC_ST_IDLE;
      end
      RBC_ST_IDLE: begin
        if (meas_enter) begin
          nxt_state = RBC_ST_MEAS;
        end else if (bias_commit_enter) begin
          nxt_state = RBC_ST_BIAS_COMMIT;
        end
      end
      RBC_ST_MEAS: begin
        if (meas_finish) begin
          nxt_state = RBC_ST_IDLE;
        end
      end
      RBC_ST_BIAS_COMMIT: begin
        if (bias_commit_finish) begin
          nxt_state = RBC_ST_IDLE;
        end
      end
    endcase
  end

  // state register; load runs once after reset release
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= RBC_ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // rail level register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rail_ff <= '{spare: RBC_RAIL_SPARE_RST, rsvd: 1'b0,
                   level: RBC_LEVEL_DEF};
    end else if (state_ff == RBC_ST_LOAD) begin
      // [RQ16] stored level load
      rail_ff.level <= i_nv_rail_level;
    end else if (wr_rail) begin
      // illegal codes are stored as written and flagged on o_rail_valid
      rail_ff.spare <= i_reg_wdata[7:4];
      rail_ff.level <= i_reg_wdata[2:0];
    end
  end

  // bias code; a finishing measurement beats a host write in that cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bias_ff <= RBC_BIAS_DEF;
    end else if (state_ff == RBC_ST_LOAD) begin
      // [RQ16] stored code load
      bias_ff <= i_nv_bias_code;
    end else if (meas_finish) begin
      // [RQ5] [RQ11] averaged result stored
      bias_ff <= avg_result;
    end else begin
      // [RQ3] low byte write
      if (wr_low) begin
        bias_ff[RBC_DATA_W-1:0] <= i_reg_wdata;
      end
      // [RQ15] msb from high byte
      if (wr_high) begin
        bias_ff[RBC_CODE_W-1] <= wr_ctrl.code_msb;
      end
    end
  end

  // start bit: a write of one wins over the clear at measurement end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff.start <= 1'b0;
    end else if (wr_high && wr_ctrl.start) begin
      // [RQ4] write one launches
      ctrl_ff.start <= 1'b1;
    end else if (meas_finish) begin
      // [RQ5] self clearing start
      ctrl_ff.start <= 1'b0;
    end
  end

  // commit bit: a write of one wins over the clear at commit end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff.commit <= 1'b0;
    end else if (wr_high && wr_ctrl.commit) begin
      // [RQ6] write one commits
      ctrl_ff.commit <= 1'b1;
    end else if (bias_commit_finish) begin
      // [RQ7] self clearing commit
      ctrl_ff.commit <= 1'b0;
    end
  end

  // plain read/write control fields; msb lives in bias_ff
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff.float_pin <= 1'b0;
      ctrl_ff.avg       <= '0;
      ctrl_ff.spare_hi  <= RBC_SPARE_HI_RST;
      ctrl_ff.spare_lo  <= 1'b0;
      ctrl_ff.code_msb  <= 1'b0;
    end else if (wr_high) begin
      ctrl_ff.float_pin <= wr_ctrl.float_pin;
      ctrl_ff.avg       <= wr_ctrl.avg;
      ctrl_ff.spare_hi  <= wr_ctrl.spare_hi;
      ctrl_ff.spare_lo  <= wr_ctrl.spare_lo;
    end
  end

  // read data; unmapped offsets read as zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        RBC_OFS_RAIL:      rdata_ff <= RBC_DATA_W'(rail_ff);
        // [RQ3] low byte readback
        RBC_OFS_BIAS_LOW:  rdata_ff <= bias_ff[RBC_DATA_W-1:0];
        // [RQ15] msb joins control bits
        RBC_OFS_BIAS_HIGH: rdata_ff <= {ctrl_ff.start, ctrl_ff.commit,
                                        ctrl_ff.float_pin, ctrl_ff.avg,
                                        ctrl_ff.spare_hi, ctrl_ff.spare_lo,
                                        bias_ff[RBC_CODE_W-1]};
        default:           rdata_ff <= '0;
      endcase
    end
  end

  // sample counter; the averaging field is frozen at launch so a host
  // write during a burst cannot change the divisor halfway
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left_ff  <= '0;
      shift_ff <= '0;
    end else if (meas_enter) begin
      // [RQ10] 1, 2, 4 or 8 samples
      left_ff  <= 4'(4'h1 << ctrl_ff.avg);
      shift_ff <= ctrl_ff.avg;
    end else if (sample_in) begin
      left_ff <= left_ff - 4'h1;
    end
  end

  // converter start: at launch and after every sample but the last
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      adc_start_ff <= 1'b0;
    end else begin
      // [RQ11] repeated conversions
      adc_start_ff <= meas_enter || (sample_in && !meas_finish);
    end
  end

  // averaging accumulator
  rbc_sample_avg #(
    .DATA_W  (RBC_CODE_W),
    .SHIFT_W (SHIFT_W)
  ) u_avg (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clear   (meas_enter),
    .i_add     (sample_in),
    .i_sample  (i_adc_data),
    .i_shift   (shift_ff),
    .o_avg     (avg_result)
  );

  // commit request held until the store answers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nv_write_ff <= 1'b0;
      nv_wdata_ff <= '0;
    end else if (bias_commit_enter) begin
      // [RQ6] code sent to store
      nv_write_ff <= 1'b1;
      nv_wdata_ff <= bias_ff;
    end else if (bias_commit_finish) begin
      nv_write_ff <= 1'b0;
    end
  end

  // completion pulses toward interrupt and power-mode logic
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meas_flag_ff   <= 1'b0;
      commit_flag_ff <= 1'b0;
      standby_ff     <= 1'b0;
    end else begin
      // [RQ13] measurement complete event
      meas_flag_ff   <= meas_finish;
      // [RQ14] commit complete event
      commit_flag_ff <= bias_commit_finish;
      // [RQ7] idle entry after commit
      standby_ff     <= bias_commit_finish;
    end
  end

  // registered analog settings
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_level_ff   <= RBC_LEVEL_DEF;
      out_valid_ff   <= 1'b1;
      out_rail_mv_ff <= RBC_MV_15000;
      out_bias_mv_ff <= '0;
      busy_ff        <= 1'b0;
    end else begin
      // [RQ1] level decode
      out_level_ff   <= rail_ff.level;
      out_valid_ff   <= (rbc_level_mv(rail_ff.level) != '0);
      out_rail_mv_ff <= rbc_level_mv(rail_ff.level);
      // [RQ12] ten millivolt steps
      out_bias_mv_ff <= 16'(16'(bias_ff) * RBC_BIAS_STEP_MV);
      busy_ff        <= (nxt_state == RBC_ST_MEAS)
                        || (nxt_state == RBC_ST_BIAS_COMMIT);
    end
  end

  assign o_reg_rdata             = rdata_ff;
  assign o_nv_write              = nv_write_ff;
  assign o_nv_wdata              = nv_wdata_ff;
  assign o_adc_start             = adc_start_ff;
  assign o_rail_level            = out_level_ff;
  assign o_rail_valid            = out_valid_ff;
  assign o_rail_mv               = out_rail_mv_ff;
  assign o_bias_code             = bias_ff;
  assign o_bias_neg_mv           = out_bias_mv_ff;
  // [RQ9] amplifier drives pin
  assign o_bias_pin_oe           = !ctrl_ff.float_pin;
  // [RQ8] pin released for measuring
  assign o_bias_pin_float        = ctrl_ff.float_pin;
  assign o_measure_done_flag_set = meas_flag_ff;
  assign o_commit_done_flag_set  = commit_flag_ff;
  assign o_enter_standby         = standby_ff;
  assign o_busy                  = busy_ff;

endmodule

// ==== rbc_rail_bias_regs_asserts.sv ====
// checker for the rail and bias register block, top-level ports only
// assumes the bind at the foot of this file attaches it to the block
`timescale 1ns/10ps
module rbc_rail_bias_regs_asserts #(
  parameter int unsigned SHIFT_W = 2  // averaging field width
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        i_nv_write_done,
  input wire logic        o_nv_write,
  input wire logic [8:0]  o_nv_wdata,
  input wire logic        i_adc_done,
  input wire logic        o_adc_start,
  input wire logic [2:0]  o_rail_level,
  input wire logic        o_rail_valid,
  input wire logic [15:0] o_rail_mv,
  input wire logic [8:0]  o_bias_code,
  input wire logic [15:0] o_bias_neg_mv,
  input wire logic        o_bias_pin_oe,
  input wire logic        o_bias_pin_float,
  input wire logic        o_measure_done_flag_set,
  input wire logic        o_commit_done_flag_set,
  input wire logic        o_enter_standby,
  input wire logic        o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // a host write to the control byte
  wire wr_ctl = i_reg_wr && (i_reg_addr == 8'h04);

  rail_valid_a: assert property (
    o_rail_valid == (o_rail_level inside {[3:6]})) else $error("valid off");
  rail_mv_a: assert property (
    o_rail_mv == (o_rail_valid ?
    16'h3A98 - 16'(o_rail_level - 3'h3) * 16'h00FA : 16'h0000))
    else $error("rail mv off");
  // first edge after release still sees the pre-load code
  bias_mv_a: assert property ($past(i_rst_n) |->
    o_bias_neg_mv == 16'($past(o_bias_code)) * 16'h000A)
    else $error("bias mv off");
  bias_read_a: assert property (i_reg_rd && i_reg_addr == 8'h03 |=>
    o_reg_rdata == 8'($past(o_bias_code))) else $error("low read off");
  msb_read_a: assert property (i_reg_rd && i_reg_addr == 8'h04 |=>
    o_reg_rdata[0] == $past(o_bias_code[8])) else $error("msb read off");
  start_launch_a: assert property (
    wr_ctl && i_reg_wdata[7] && !o_busy |-> ##[1:4] o_adc_start)
    else $error("no launch");
  adc_next_a: assert property (
    i_adc_done && o_busy && !o_nv_write |=>
    o_adc_start || o_measure_done_flag_set) else $error("no next sample");
  idle_done_a: assert property (!o_busy && i_adc_done |=>
    !o_measure_done_flag_set && !o_adc_start) else $error("idle sample");
  commit_launch_a: assert property (
    wr_ctl && i_reg_wdata[7:6] == 2'b01 && !o_busy |-> ##[1:3] o_nv_write)
    else $error("no commit");
  nv_hold_a: assert property (o_nv_write && $past(o_nv_write) |->
    $stable(o_nv_wdata)) else $error("commit data moved");
  commit_end_a: assert property (o_nv_write && i_nv_write_done |=>
    !o_nv_write && o_commit_done_flag_set && !o_busy)
    else $error("commit not ended");
  flag_pair_a: assert property (
    o_commit_done_flag_set == o_enter_standby) else $error("flags differ");
  float_write_a: assert property (wr_ctl |=>
    o_bias_pin_float == $past(i_reg_wdata[5])) else $error("float lost");
  pin_oe_a: assert property (o_bias_pin_oe != o_bias_pin_float)
    else $error("oe not inverse");

  cover property (o_measure_done_flag_set);
  cover property (o_commit_done_flag_set);
  cover property (o_adc_start && o_bias_pin_float);
endmodule

bind rbc_rail_bias_regs rbc_rail_bias_regs_asserts #(.SHIFT_W(SHIFT_W)) chk_u (
  .i_sys_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
  .o_reg_rdata, .i_nv_write_done, .o_nv_write, .o_nv_wdata, .i_adc_done,
  .o_adc_start, .o_rail_level, .o_rail_valid, .o_rail_mv, .o_bias_code,
  .o_bias_neg_mv, .o_bias_pin_oe, .o_bias_pin_float, .o_measure_done_flag_set,
  .o_commit_done_flag_set, .o_enter_standby, .o_busy);

// ==== rbc_rail_bias_regs_test.sv ====
// self-checking bench for the rail and bias register block
// assumes the far-side model answers the converter and store ports
`timescale 1ns/10ps
module rbc_rail_bias_regs_test;
  import rbc_pkg::*;
  logic        i_sys_clk   = 1'b0;   // 250 MHz
  logic        i_rst_n     = 1'b0;   // held 16 cycles
  logic [7:0]  i_reg_addr  = 8'h00;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_reg_wr    = 1'b0;
  logic        i_reg_rd    = 1'b0;
  logic [2:0]  i_nv_rail_level;      // stored defaults, set at time zero
  logic [8:0]  i_nv_bias_code;
  logic [3:0]  lat         = 4'h0;   // far-side answer delay
  logic [8:0]  nv_seen     = 9'h000; // code seen on the store port
  wire  [7:0]  o_reg_rdata;
  wire         o_nv_write, i_nv_write_done, i_adc_done, o_adc_start;
  wire  [8:0]  o_nv_wdata, i_adc_data, o_bias_code;
  wire  [2:0]  o_rail_level;
  wire         o_rail_valid, o_bias_pin_oe, o_bias_pin_float, o_busy;
  wire  [15:0] o_rail_mv, o_bias_neg_mv;
  wire         o_measure_done_flag_set, o_commit_done_flag_set;
  wire         o_enter_standby;
  int          fails = 0;
  int          samples_checked = 0;
  int          m_code, m_ctl, m_lvl, sum, n, t;  // reference model state

  rbc_rail_bias_regs #(.SHIFT_W(2)) dut_u (.i_sys_clk, .i_rst_n,
    .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_nv_rail_level, .i_nv_bias_code, .i_nv_write_done, .o_nv_write,
    .o_nv_wdata, .i_adc_done, .i_adc_data, .o_adc_start, .o_rail_level,
    .o_rail_valid, .o_rail_mv, .o_bias_code, .o_bias_neg_mv, .o_bias_pin_oe,
    .o_bias_pin_float, .o_measure_done_flag_set, .o_commit_done_flag_set,
    .o_enter_standby, .o_busy);
  rbc_far_model far_u (.i_sys_clk, .i_rst_n, .i_adc_start(o_adc_start),
    .i_nv_write(o_nv_write), .i_lat(lat), .o_adc_done(i_adc_done),
    .o_adc_data(i_adc_data), .o_nv_write_done(i_nv_write_done));

  always #2 i_sys_clk = ~i_sys_clk;
  // samples summed here give the expected average
  always @(posedge i_sys_clk) if (i_adc_done === 1'b1) begin
    sum += i_adc_data;
    n++;
  end
  always @(posedge i_sys_clk) if (o_nv_write === 1'b1) nv_seen <= o_nv_wdata;

  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes move on falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr    = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_rd   = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd   = 1'b0;
    chk_out(16'(o_reg_rdata), 16'(exp));
  endtask
  // bounded wait for a completion pulse
  task automatic wait_ev(input bit commit);
    t = 0;
    while ((commit ? o_commit_done_flag_set : o_measure_done_flag_set)
           !== 1'b1 && t < 400) begin
      @(negedge i_sys_clk);
      t++;
    end
    chk_out(16'(t < 400), 16'h0001);
  endtask

  // about 350 cycles needed
  initial begin
    #100000;
    fails++;
    close_out();
  end

  initial begin
    void'($urandom(81));
    i_nv_rail_level = 3'($urandom_range(6, 3));
    i_nv_bias_code  = 9'($urandom);
    repeat (16) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    m_code = i_nv_bias_code;
    m_lvl  = 8'h20 | i_nv_rail_level;
    m_ctl  = 8'h04;
    rd(8'h02, 8'(m_lvl));
    rd(8'h03, 8'(m_code));
    rd(8'h04, 8'(m_ctl | (m_code >> 8)));
    $display("test power-up load done");
    for (int i = 3; i <= 6; i++) begin
      // only legal level codes are written
      m_lvl  = ($urandom & 8'hF0) | i;
      m_code = $urandom_range(511, 0);
      m_ctl  = $urandom & 8'h3E;
      wr(8'h02, 8'(m_lvl | 8'h08));
      wr(8'h03, 8'(m_code));
      wr(8'h04, 8'(m_ctl | (m_code >> 8)));
      rd(8'h02, 8'(m_lvl));
      chk_out(o_rail_mv, 16'(15000 - (i - 3) * 250));
      chk_out(o_bias_neg_mv, 16'(m_code * 10));
      rd(8'h03, 8'(m_code));
      rd(8'h04, 8'(m_ctl | (m_code >> 8)));
      chk_out(16'(o_bias_pin_float), 16'(m_ctl[5]));
      chk_out(16'(o_bias_pin_oe), 16'(!m_ctl[5]));
      chk_out(16'(o_busy), 16'h0000);
    end
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    $display("test register access done");
    for (int a = 0; a < 4; a++) begin
      lat   = 4'(a * 3);
      sum   = 0;
      n     = 0;
      m_ctl = 8'h20 | (a << 3);
      wr(8'h04, 8'(m_ctl | 8'h80 | (m_code >> 8)));
      wait_ev(1'b0);
      m_code = sum / (1 << a);
      chk_out(16'(n), 16'(1 << a));
      chk_out({7'h00, o_bias_code}, 16'(m_code));
      rd(8'h04, 8'(m_ctl | (m_code >> 8)));
    end
    $display("test measurement done");
    // commit alone, then measure and commit in one write
    for (int c = 0; c < 2; c++) begin
      lat = 4'(5 + c * 4);
      sum = 0;
      n   = 0;
      wr(8'h04, 8'(m_ctl | 8'h40 | (c << 7) | (m_code >> 8)));
      if (c == 1) begin
        wait_ev(1'b0);
        m_code = sum / 8;
      end
      wait_ev(1'b1);
      chk_out(16'(o_enter_standby), 16'h0001);
      chk_out({7'h00, nv_seen}, 16'(m_code));
      rd(8'h04, 8'(m_ctl | (m_code >> 8)));
    end
    $display("test commit done");
    close_out();
  end
endmodule

// ==== rbc_sample_avg.sv ====
// accumulator that averages a power-of-two number of converter samples
// assumes the caller clears it before a burst and adds one sample a pulse
`timescale 1ns/10ps
module rbc_sample_avg #(
  parameter int unsigned DATA_W  = 9,  // sample width
  parameter int unsigned SHIFT_W = 2   // width of i_shift, the log2 sample count
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_clear,   // start of a burst
  input  wire logic              i_add,     // one sample present
  input  wire logic [DATA_W-1:0] i_sample,  // converter result
  input  wire logic [SHIFT_W-1:0] i_shift,  // log2 of sample count
  output logic      [DATA_W-1:0] o_avg      // average including i_sample
);

  localparam int unsigned SUM_W = DATA_W + (1 << SHIFT_W) - 1;

  logic [SUM_W-1:0] sum_ff;     // running sum of earlier samples
  logic [SUM_W-1:0] nxt_sum;    // sum including the present sample
  logic [SUM_W-1:0] shifted;    // sum scaled back to one sample

  // the present sample is folded in so the last one needs no extra cycle
  always_comb begin
    nxt_sum = sum_ff + SUM_W'(i_sample);
    shifted = nxt_sum >> i_shift;
  end

  // truncating division, the average always rounds toward zero
  assign o_avg = shifted[DATA_W-1:0];

  // sum register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_ff <= '0;
    end else if (i_clear) begin
      sum_ff <= '0;
    end else if (i_add) begin
      sum_ff <= nxt_sum;
    end
  end

endmodule
